// ===== design/ertst_defines.svh
// Offsets, field positions, reset values and counts of the run-length test block
`ifndef ERTST_DEFINES_SVH
`define ERTST_DEFINES_SVH
`define ERTST_OFS_MAIN_CTRL 8'h00
`define ERTST_OFS_MISC      8'h0C
`define ERTST_OFS_RUN5      8'h34
`define ERTST_OFS_RUN6      8'h38
`define ERTST_OFS_STAT      8'h3C
`define ERTST_BIT_PROG_MODE 16
`define ERTST_BIT_ERR       12
`define ERTST_BIT_ENTV      10
`define ERTST_BIT_RSTDEF    6
`define ERTST_BIT_DIS       5
`define ERTST_RTY_LSB       16
`define ERTST_RTY_RST       4'h1
`define ERTST_R5_RNG_RST    11'h013
`define ERTST_R5_MAX_RST    11'h012
`define ERTST_R6_RNG_RST    11'h012
`define ERTST_R6_MAX_RST    11'h011
`define ERTST_DIS_RNG       11'h7FF
`define ERTST_DIS_MAX       11'h7FE
`define ERTST_SAMPLE_LAST   12'h3FF
`endif

// ===== design/ertst_pkg.sv
// Types shared by the run-length test block
package ertst_pkg;
    typedef struct packed {
        logic [10:0] rng;
        logic [10:0] max;
    } ertst_limit_t;

    // Results of the tests computed outside this block
    typedef struct packed {
        logic monobit_fail;
        logic poker_fail;
        logic long_run_fail;
        logic sparse_bit_fail;
        logic len4_ones_fail;
        logic len4_zeros_fail;
        logic len3_ones_fail;
        logic len3_zeros_fail;
        logic len2_ones_fail;
        logic len2_zeros_fail;
        logic len1_ones_fail;
        logic len1_zeros_fail;
    } ertst_ext_fail_t;

    typedef enum logic [2:0] {ST_IDLE, ST_GEN, ST_SETTLE, ST_EVAL, ST_DONE, ST_ERR} ertst_state_t;
endpackage : ertst_pkg

// ===== design/ertst_run_tracker.sv
// Finds bounded runs of five and of six or more equal bits in the sample stream
`timescale 1ns/1ps
module ertst_run_tracker (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Control and samples
    input  wire logic       clear,
    input  wire logic       bit_valid,
    input  wire logic       bit_in,
    // Run events, one-cycle pulses
    output logic            ev5_one_q,
    output logic            ev5_zero_q,
    output logic            ev6_one_q,
    output logic            ev6_zero_q
);
    logic       last_q;
    logic [2:0] len_q;
    logic       seen_q;
    logic       bounded_q;

    // Run length saturates at six, so every longer run counts as one six-plus run
    always_ff @(posedge clk_sys)
    begin
        if (srst || clear)
        begin
            last_q    <= 1'b0;
            len_q     <= 3'h0;
            seen_q    <= 1'b0;
            bounded_q <= 1'b0;
        end
        else if (bit_valid)
        begin
            if (!seen_q)
            begin
                seen_q <= 1'b1;
                last_q <= bit_in;
                len_q  <= 3'h1;
            end
            else if (bit_in == last_q)
            begin
                len_q <= (len_q == 3'h6) ? 3'h6 : len_q + 3'h1;
            end
            else
            begin
                last_q    <= bit_in;
                len_q     <= 3'h1;
                bounded_q <= 1'b1;
            end
        end
    end

    // A run counts only when an opposite bit stands on both sides of it
    always_ff @(posedge clk_sys)
    begin
        if (srst || clear)
        begin
            ev5_one_q  <= 1'b0;
            ev5_zero_q <= 1'b0;
            ev6_one_q  <= 1'b0;
            ev6_zero_q <= 1'b0;
        end
        else
        begin
            ev5_one_q  <= bit_valid && bounded_q && (bit_in != last_q) && last_q && (len_q == 3'h5);
            ev5_zero_q <= bit_valid && bounded_q && (bit_in != last_q) && !last_q && (len_q == 3'h5);
            ev6_one_q  <= bit_valid && bounded_q && (bit_in != last_q) && last_q && (len_q == 3'h6);
            ev6_zero_q <= bit_valid && bounded_q && (bit_in != last_q) && !last_q && (len_q == 3'h6);
        end
    end
endmodule : ertst_run_tracker

// ===== design/ertst_limit_counter.sv
// Pair of down counters for one run length, with pass/fail against the limits
`timescale 1ns/1ps
module ertst_limit_counter (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    // Control
    input  wire logic                  load,
    input  wire ertst_pkg::ertst_limit_t limit,
    input  wire logic                  dec_one,
    input  wire logic                  dec_zero,
    // Counts and verdicts
    output logic [10:0]                ones_q,
    output logic [10:0]                zeros_q,
    output logic                       fail_ones,
    output logic                       fail_zeros
);
    // Counters start at the maximum and stop at zero instead of wrapping
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ones_q  <= 11'h000;
            zeros_q <= 11'h000;
        end
        else if (load)
        begin
            ones_q  <= limit.max;
            zeros_q <= limit.max;
        end
        else
        begin
            if (dec_one && ones_q != 11'h000)
                ones_q <= ones_q - 11'h001;
            if (dec_zero && zeros_q != 11'h000)
                zeros_q <= zeros_q - 11'h001;
        end
    end

    // Runs = max - count; runs < max means count > 0, runs > max - rng means count < rng
    assign fail_ones  = (ones_q == 11'h000) || (ones_q >= limit.rng);
    assign fail_zeros = (zeros_q == 11'h000) || (zeros_q >= limit.rng);
endmodule : ertst_limit_counter

// ===== design/ertst_run_status.sv
// APB register block, run-length 5 and 6+ checks, retry sequencing and test status
//
// The APB register port was chosen for this implementation.
`include "ertst_defines.svh"
`timescale 1ns/1ps
module ertst_run_status (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Sample stream and results of the other tests, same clock
    input  wire logic                     sample_valid,
    input  wire logic                     sample_bit,
    input  wire ertst_pkg::ertst_ext_fail_t ext_fail,
    // Generation state
    output logic                          gen_active,
    output logic                          entropy_valid,
    output logic                          test_error
);
    ertst_pkg::ertst_state_t    state_q;
    ertst_pkg::ertst_limit_t    lim5_q;
    ertst_pkg::ertst_limit_t    lim6_q;
    logic                       program_mode_q;
    logic [3:0]                 retry_setting_q;
    logic [3:0]                 retries_left_q;
    logic [15:0]                status_q;
    logic [11:0]                sample_cnt_q;
    logic                       acc_done;
    logic                       wr_ctrl;
    logic                       wr_misc;
    logic                       start;
    logic                       restart;
    logic                       load;
    logic                       any_fail;
    logic [10:0]                r5_ones;
    logic [10:0]                r5_zeros;
    logic [10:0]                r6_ones;
    logic [10:0]                r6_zeros;
    logic                       f5_ones;
    logic                       f5_zeros;
    logic                       f6_ones;
    logic                       f6_zeros;
    logic                       ev5_one;
    logic                       ev5_zero;
    logic                       ev6_one;
    logic                       ev6_zero;
    logic [31:0]                rd_d;
    logic                       err_d;

    // Two 11-bit fields placed at 26:16 and 10:0
    function automatic logic [31:0] pack_pair(input logic [10:0] hi, input logic [10:0] lo);
        pack_pair = {5'h00, hi, 5'h00, lo};
    endfunction : pack_pair

    // Write acts only at the edge where the master sees pready high
    assign acc_done = psel && penable && pready;
    assign wr_ctrl  = acc_done && pwrite && (paddr == `ERTST_OFS_MAIN_CTRL);
    assign wr_misc  = acc_done && pwrite && (paddr == `ERTST_OFS_MISC);
    // Leaving program mode starts a fresh generation
    assign start    = wr_ctrl && program_mode_q && !pwdata[`ERTST_BIT_PROG_MODE];
    assign any_fail = f5_ones || f5_zeros || f6_ones || f6_zeros || (|ext_fail);
    assign restart  = (state_q == ertst_pkg::ST_EVAL) && any_fail
                      && (retries_left_q != 4'h0);
    assign load     = start || restart;

    ertst_run_tracker u_tracker (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .clear      (load),
        .bit_valid  (sample_valid && (state_q == ertst_pkg::ST_GEN)),
        .bit_in     (sample_bit),
        .ev5_one_q  (ev5_one),
        .ev5_zero_q (ev5_zero),
        .ev6_one_q  (ev6_one),
        .ev6_zero_q (ev6_zero)
    );

    // Length-5 counters loaded from the programmed maximum
    ertst_limit_counter u_cnt5 (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .load       (load),
        .limit      (lim5_q),
        .dec_one    (ev5_one),
        .dec_zero   (ev5_zero),
        .ones_q     (r5_ones),
        .zeros_q    (r5_zeros),
        .fail_ones  (f5_ones),
        .fail_zeros (f5_zeros)
    );

    // Six-plus counters loaded from the programmed maximum
    ertst_limit_counter u_cnt6 (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .load       (load),
        .limit      (lim6_q),
        .dec_one    (ev6_one),
        .dec_zero   (ev6_zero),
        .ones_q     (r6_ones),
        .zeros_q    (r6_zeros),
        .fail_ones  (f6_ones),
        .fail_zeros (f6_zeros)
    );

    // Program/run mode bit
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            program_mode_q <= 1'b1;
        else if (wr_ctrl)
            program_mode_q <= pwdata[`ERTST_BIT_PROG_MODE];
    end

    // Limit registers; self-test disable wins if both action bits are written together
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            lim5_q <= '{rng: `ERTST_R5_RNG_RST, max: `ERTST_R5_MAX_RST};
            lim6_q <= '{rng: `ERTST_R6_RNG_RST, max: `ERTST_R6_MAX_RST};
        end
        else if (wr_ctrl && pwdata[`ERTST_BIT_DIS])
        begin
            lim5_q <= '{rng: `ERTST_DIS_RNG, max: `ERTST_DIS_MAX};
            lim6_q <= '{rng: `ERTST_DIS_RNG, max: `ERTST_DIS_MAX};
        end
        else if (wr_ctrl && pwdata[`ERTST_BIT_RSTDEF])
        begin
            lim5_q <= '{rng: `ERTST_R5_RNG_RST, max: `ERTST_R5_MAX_RST};
            lim6_q <= '{rng: `ERTST_R6_RNG_RST, max: `ERTST_R6_MAX_RST};
        end
        else if (acc_done && pwrite && program_mode_q)
        begin
            // In run mode the same offsets are read-only counts, so writes drop out
            if (paddr == `ERTST_OFS_RUN5)
                lim5_q <= '{rng: pwdata[26:16], max: pwdata[10:0]};
            if (paddr == `ERTST_OFS_RUN6)
                lim6_q <= '{rng: pwdata[26:16], max: pwdata[10:0]};
        end
    end

    // Retry setting and live retry count; a software write wins over a decrement
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            retry_setting_q <= `ERTST_RTY_RST;
            retries_left_q  <= `ERTST_RTY_RST;
        end
        else if (wr_misc)
        begin
            retry_setting_q <= pwdata[`ERTST_RTY_LSB +: 4];
            retries_left_q  <= pwdata[`ERTST_RTY_LSB +: 4];
        end
        else if (start)
            retries_left_q <= retry_setting_q;
        else if (restart)
            retries_left_q <= retries_left_q - 4'h1;
    end

    // Generation sequence: sample, let the counters settle one cycle, then judge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state_q <= ertst_pkg::ST_IDLE;
        else if (wr_ctrl && pwdata[`ERTST_BIT_PROG_MODE])
            state_q <= ertst_pkg::ST_IDLE;
        else if (load)
            state_q <= ertst_pkg::ST_GEN;
        else
        begin
            unique case (state_q)
                ertst_pkg::ST_IDLE:   state_q <= ertst_pkg::ST_IDLE;
                ertst_pkg::ST_GEN:
                    if (sample_valid && sample_cnt_q == `ERTST_SAMPLE_LAST)
                        state_q <= ertst_pkg::ST_SETTLE;
                ertst_pkg::ST_SETTLE: state_q <= ertst_pkg::ST_EVAL;
                ertst_pkg::ST_EVAL:
                    state_q <= any_fail ? ertst_pkg::ST_ERR : ertst_pkg::ST_DONE;
                ertst_pkg::ST_DONE:   state_q <= ertst_pkg::ST_DONE;
                ertst_pkg::ST_ERR:    state_q <= ertst_pkg::ST_ERR;
                default:              state_q <= ertst_pkg::ST_IDLE;
            endcase
        end
    end

    // Sample counter restarts with every generation attempt
    always_ff @(posedge clk_sys)
    begin
        if (srst || load)
            sample_cnt_q <= 12'h000;
        else if (state_q == ertst_pkg::ST_GEN && sample_valid)
            sample_cnt_q <= sample_cnt_q + 12'h001;
    end

    // Test results are latched at each judgement, retries included
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            status_q <= 16'h0000;
        else if (state_q == ertst_pkg::ST_EVAL)
            status_q <= {ext_fail.monobit_fail, ext_fail.poker_fail,
                         ext_fail.long_run_fail, ext_fail.sparse_bit_fail,
                         f6_ones, f6_zeros, f5_ones, f5_zeros,
                         ext_fail.len4_ones_fail, ext_fail.len4_zeros_fail,
                         ext_fail.len3_ones_fail, ext_fail.len3_zeros_fail,
                         ext_fail.len2_ones_fail, ext_fail.len2_zeros_fail,
                         ext_fail.len1_ones_fail, ext_fail.len1_zeros_fail};
    end

    // Read decode; shared offsets flip with the mode bit
    always_comb
    begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        unique case (paddr)
            `ERTST_OFS_MAIN_CTRL:
            begin
                rd_d[`ERTST_BIT_PROG_MODE] = program_mode_q;
                rd_d[`ERTST_BIT_ERR]  = (state_q == ertst_pkg::ST_ERR);
                rd_d[`ERTST_BIT_ENTV] = (state_q == ertst_pkg::ST_DONE);
            end
            `ERTST_OFS_MISC: rd_d[`ERTST_RTY_LSB +: 4] = retry_setting_q;
            `ERTST_OFS_RUN5:
                rd_d = program_mode_q ? pack_pair(lim5_q.rng, lim5_q.max)
                                      : pack_pair(r5_ones, r5_zeros);
            `ERTST_OFS_RUN6:
                rd_d = program_mode_q ? pack_pair(lim6_q.rng, lim6_q.max)
                                      : pack_pair(r6_ones, r6_zeros);
            `ERTST_OFS_STAT:
                if (!program_mode_q)
                    rd_d = {12'h000, retries_left_q, status_q};
            default: err_d = 1'b1;
        endcase
    end

    // One wait state: data and error are registered in the first access cycle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h0000_0000;
            pslverr <= psel && penable && !pready && err_d;
        end
    end

    // Status outputs, registered
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            gen_active    <= 1'b0;
            entropy_valid <= 1'b0;
            test_error    <= 1'b0;
        end
        else
        begin
            gen_active    <= (state_q == ertst_pkg::ST_GEN) || (state_q == ertst_pkg::ST_SETTLE);
            entropy_valid <= (state_q == ertst_pkg::ST_DONE);
            test_error    <= (state_q == ertst_pkg::ST_ERR);
        end
    end

    a_stat_prog_zero: assert property (@(posedge clk_sys) disable iff (srst)
        psel && penable && !pready && !pwrite && paddr == `ERTST_OFS_STAT && program_mode_q
        |=> prdata == 32'h0000_0000) else $error("status not zero in program mode");
    a_retry_decrement: assert property (@(posedge clk_sys) disable iff (srst)
        restart && !wr_misc |=> retries_left_q == $past(retries_left_q) - 4'h1
        && state_q == ertst_pkg::ST_GEN) else $error("retry did not decrement");
    a_fail_error: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == ertst_pkg::ST_EVAL && any_fail && retries_left_q == 4'h0 && !wr_ctrl
        |=> state_q == ertst_pkg::ST_ERR ##1 test_error) else $error("no error raised");
    a_retry_default: assert property (@(posedge clk_sys)
        $past(srst) && srst |=> retry_setting_q == 4'h1) else $error("retry default wrong");
    a_dis_limits: assert property (@(posedge clk_sys) disable iff (srst)
        wr_ctrl && pwdata[`ERTST_BIT_DIS] |=> lim5_q.rng == 11'h7FF && lim5_q.max == 11'h7FE
        && lim6_q.rng == 11'h7FF && lim6_q.max == 11'h7FE) else $error("disable load wrong");
    a_rstdef_limits: assert property (@(posedge clk_sys) disable iff (srst)
        wr_ctrl && pwdata[`ERTST_BIT_RSTDEF] && !pwdata[`ERTST_BIT_DIS]
        |=> lim5_q.max == 11'h012 && lim5_q.rng == 11'h013 && lim6_q.max == 11'h011
        && lim6_q.rng == 11'h012) else $error("restore defaults wrong");
    a_ro_write_ignored: assert property (@(posedge clk_sys) disable iff (srst)
        acc_done && pwrite && !program_mode_q && paddr == `ERTST_OFS_RUN5
        |=> $stable(lim5_q)) else $error("readback write changed limit");
    a_r5_status_map: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == ertst_pkg::ST_EVAL |=> status_q[9:8] == $past({f5_ones, f5_zeros})
        && status_q[11:10] == $past({f6_ones, f6_zeros})) else $error("status map wrong");
    a_cnt_load_max: assert property (@(posedge clk_sys) disable iff (srst)
        load |=> r5_ones == $past(lim5_q.max) && r6_zeros == $past(lim6_q.max))
        else $error("load wrong");
    // Every access gets exactly one wait state
    a_ready_wait: assert property (@(posedge clk_sys) disable iff (srst)
        psel && penable && !pready |=> pready) else $error("pready not after one wait");
    // Each start reloads the live retry count from the setting
    a_retry_reload: assert property (@(posedge clk_sys) disable iff (srst)
        start |=> retries_left_q == $past(retry_setting_q)) else $error("retry not reloaded");

    c_pass_done: cover property (@(posedge clk_sys) disable iff (srst)
        state_q == ertst_pkg::ST_EVAL && !any_fail);
    c_retry: cover property (@(posedge clk_sys) disable iff (srst) restart);
    c_error: cover property (@(posedge clk_sys) disable iff (srst) $rose(test_error));
    c_dis_load: cover property (@(posedge clk_sys) disable iff (srst)
        wr_ctrl && pwdata[`ERTST_BIT_DIS]);
    c_ro_write: cover property (@(posedge clk_sys) disable iff (srst)
        acc_done && pwrite && !program_mode_q);
endmodule : ertst_run_status

// ===== sim/ertst_tb.sv
// Self-checking bench for the run-length test and status block
`timescale 1ns/1ps
`include "ertst_defines.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic                      clk_sys, srst, psel, penable, pwrite;
    logic                      sample_valid, sample_bit, feed_en;
    logic [7:0]                paddr;
    logic [31:0]               pwdata, prdata;
    logic                      pready, pslverr, gen_active, entropy_valid, test_error;
    ertst_pkg::ertst_ext_fail_t ext_fail;
    ertst_pkg::ertst_limit_t   lim5, lim6;
    logic [32:0]               exp_q[$];
    logic [32:0]               seen;
    logic                      stream[1024];
    logic [3:0]                rty;
    int                        idx, seed, error_cnt, compares, n5[2], n6[2];

    ertst_run_status i_dut (
        .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_bit(sample_bit), .ext_fail(ext_fail), .gen_active(gen_active),
        .entropy_valid(entropy_valid), .test_error(test_error));

    // Clock at 20 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [10:0] cnt(input logic [10:0] mx, input int runs);
        return (mx > runs) ? 11'(mx - runs) : 11'h000;
    endfunction : cnt
    function automatic logic flg(input logic [10:0] c, input logic [10:0] rg);
        return (c == 11'h000) || (c >= rg);
    endfunction : flg
    function automatic logic [31:0] lreg(input ertst_pkg::ertst_limit_t l);
        return {5'h00, l.rng, 5'h00, l.max};
    endfunction : lreg

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Bus master; the trailing idle edge keeps back-to-back calls from double-driving psel
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            $display("ERROR pready expected 1 seen timeout");
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Read checker: oldest expectation against {pslverr, prdata}
    always @(posedge clk_sys)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            seen = exp_q.size() ? exp_q.pop_front() : 33'h1_FFFF_FFFF;
            `CHK("apb read", seen, {pslverr, prdata})
        end
    end

    // Sample feeder replays the stored stream; the start write sets the origin and every
    // 1026 edges later (1024 samples, settle, judge) a retry begins from bit 0 again
    always @(posedge clk_sys)
    begin
        if (!feed_en)
            idx = 2000;
        else if (psel && penable && pready === 1'b1 && pwrite
                 && paddr == `ERTST_OFS_MAIN_CTRL && !pwdata[`ERTST_BIT_PROG_MODE])
            idx = 0;
        else
            idx = (idx == 1025) ? 0 : idx + 1;
        if (idx == 512)
            `CHK("gen_active", 1'b1, gen_active)
        sample_bit <= stream[idx % 1024];
        sample_valid <= feed_en;
    end

    // Fresh random stream; only runs closed on both sides are counted
    task automatic new_stream();
        int st;
        n5 = '{0, 0};
        n6 = '{0, 0};
        st = 0;
        foreach (stream[i]) stream[i] = 1'($random(seed));
        for (int i = 1; i < 1024; i++)
        begin
            if (stream[i] != stream[i-1])
            begin
                if (st > 0 && i - st == 5) n5[stream[i-1]]++;
                if (st > 0 && i - st >= 6) n6[stream[i-1]]++;
                st = i;
            end
        end
    endtask : new_stream

    task automatic run_gen(input logic [11:0] ef);
        logic [10:0] c5o, c5z, c6o, c6z;
        logic [3:0]  fl;
        logic        bad;
        int          n;
        c5o = cnt(lim5.max, n5[1]);
        c5z = cnt(lim5.max, n5[0]);
        c6o = cnt(lim6.max, n6[1]);
        c6z = cnt(lim6.max, n6[0]);
        fl = {flg(c6o, lim6.rng), flg(c6z, lim6.rng), flg(c5o, lim5.rng), flg(c5z, lim5.rng)};
        bad = (fl != 4'h0) || (ef != 12'h000);
        ext_fail <= ef;
        feed_en <= 1'b1;
        wr(`ERTST_OFS_MAIN_CTRL, 32'h0000_0000);
        n = 0;
        while (entropy_valid !== 1'b1 && test_error !== 1'b1 && n < 8000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 8000)
        begin
            error_cnt++;
            $display("ERROR generation expected done seen timeout");
            wrap_up();
        end
        feed_en <= 1'b0;
        `CHK("test_error", bad, test_error)
        `CHK("entropy_valid", !bad, entropy_valid)
        `CHK("gen_active", 1'b0, gen_active)
        rd(`ERTST_OFS_MAIN_CTRL, {20'h00000, bad, 1'b0, !bad, 10'h000});
        rd(`ERTST_OFS_RUN5, {6'h00, c5o, 5'h00, c5z});
        rd(`ERTST_OFS_RUN6, {6'h00, c6o, 5'h00, c6z});
        rd(`ERTST_OFS_STAT, {13'h0000, bad ? 4'h0 : rty, ef[11:8], fl, ef[7:0]});
        wr(`ERTST_OFS_RUN5, 32'h0000_0000);
        wr(`ERTST_OFS_STAT, 32'hFFFF_FFFF);
        rd(`ERTST_OFS_STAT, {13'h0000, bad ? 4'h0 : rty, ef[11:8], fl, ef[7:0]});
        rd(`ERTST_OFS_RUN5, {6'h00, c5o, 5'h00, c5z});
        wr(`ERTST_OFS_MAIN_CTRL, 32'h0001_0000);
        rd(`ERTST_OFS_RUN5, {1'b0, lreg(lim5)});
        $display("test generation done, failed=%0d", bad);
    endtask : run_gen

    initial
    begin
        {srst, psel, penable, pwrite, feed_en, sample_valid, sample_bit} = 7'h41;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ext_fail = 12'h000;
        seed = 33;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd(`ERTST_OFS_RUN5, 33'h0_0013_0012);
        rd(`ERTST_OFS_RUN6, 33'h0_0012_0011);
        rd(`ERTST_OFS_STAT, 33'h0_0000_0000);
        rd(`ERTST_OFS_MISC, 33'h0_0001_0000);
        rd(8'h10, 33'h1_0000_0000);
        wr(`ERTST_OFS_RUN5, 32'h0155_0123);
        wr(`ERTST_OFS_RUN6, 32'h0234_0345);
        rd(`ERTST_OFS_RUN6, 33'h0_0234_0345);
        wr(`ERTST_OFS_MAIN_CTRL, 32'h0001_0040);
        rd(`ERTST_OFS_RUN5, 33'h0_0013_0012);
        rd(`ERTST_OFS_RUN6, 33'h0_0012_0011);
        wr(`ERTST_OFS_MAIN_CTRL, 32'h0001_0020);
        rd(`ERTST_OFS_RUN5, 33'h0_07FF_07FE);
        rd(`ERTST_OFS_RUN6, 33'h0_07FF_07FE);
        $display("test limits done");
        // Passing run with a raised retry setting
        lim5 = {11'h7FF, 11'h7FE};
        lim6 = lim5;
        rty = 4'h3;
        wr(`ERTST_OFS_MISC, 32'h0003_0000);
        rd(`ERTST_OFS_MISC, 33'h0_0003_0000);
        new_stream();
        run_gen(12'h000);
        // Limits set at the pass/fail edge: one retry, then error
        rty = 4'h1;
        wr(`ERTST_OFS_MISC, 32'h0001_0000);
        new_stream();
        lim5 = {11'h002, 11'(n5[1] + 1)};
        lim6 = {11'h7FF, 11'(n6[0])};
        wr(`ERTST_OFS_RUN5, lreg(lim5));
        wr(`ERTST_OFS_RUN6, lreg(lim6));
        run_gen(12'h000);
        // Another test failing with no retries left
        rty = 4'h0;
        wr(`ERTST_OFS_MISC, 32'h0000_0000);
        lim5 = {11'h7FF, 11'h7FE};
        lim6 = lim5;
        wr(`ERTST_OFS_MAIN_CTRL, 32'h0001_0020);
        new_stream();
        run_gen(12'($random(seed)) | 12'h001);
        wrap_up();
    end
endmodule : testbench
